// *** rtl/mbl_dev.sv ***
// Operation
// - Size bit picks 16 or 32-bit displacement
// - Evaluate six-bit selector, return completion directives
// - Even codes test flag set, odd clear
// - Loop condition true: next instruction, nothing else
// - Condition false: decrement counter low half
// - Loop target is address plus two plus displacement
// - Counter field picks register; ext upper zero
// - Flushes only in supervisor, else trap
// - Flush-all clears every cache entry; a load in the same cycle keeps its entry valid
// - Flush entries whose masked code matches
// - Address flush also needs tag match
// - Shared entries survive unless shared variant
// - Three-bit mode field selects flush operation
// - Mask one includes bit, zero excludes
// - Flush-all issuer codes mask and source zero
// - Five-bit source: immediate, data, source, destination
// - Source or destination code is three bits
// - Address flush allows control alterable modes only
// - Evaluated address is the logical address itself
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module mbl_dev (
  // Clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_n_in,
  // Coprocessor link
  mbl_cpi_if.dev                         cpi,
  // Status flags B,L,S,A,W,I,G,C at bits 0..7
  input  wire logic [7:0]                status_flags_in,
  // Cache entry load
  input  wire logic                      load_in,
  input  wire logic [2:0]                load_idx_in,
  input  wire logic [3:0]                load_fc_in,
  input  wire logic                      load_shared_in,
  input  wire logic [mbl_pkg::TAG_W-1:0] load_tag_in,
  // Cache observation
  output logic [mbl_pkg::CACHE_N-1:0]    entry_valid_out
);
  mbl_pkg::mbl_dev_state_type state_r;
  // Decode results, all combinational from the held words
  logic       is_br;
  logic       is_loop;
  logic       is_fl;
  logic [5:0] sel;
  logic       sel_ok;
  logic       cond;
  logic [2:0] fmode;
  logic [3:0] mask;
  logic [4:0] fsrc;
  logic [3:0] fc_val;
  logic       fc_ok;
  logic       ea_ok;
  logic       all_q;
  logic       addr_q;
  logic       shared_q;
  logic       illegal;
  logic       take;
  logic       flush_go;
  logic [mbl_pkg::TAG_W-1:0] ea_tag;

  // Command recognition and condition test
  always_comb
  begin
    is_br   = cpi.op_word[15:7] == mbl_pkg::OP_BR_PFX;
    is_loop = cpi.op_word[15:3] == mbl_pkg::OP_LOOP_PFX;
    is_fl   = (cpi.op_word[15:6] == mbl_pkg::OP_FLUSH_PFX)
              && (cpi.ext_word[15:13] == mbl_pkg::EXT_FLUSH);
    sel     = is_br ? cpi.op_word[5:0] : cpi.ext_word[5:0];
    sel_ok  = sel[5:4] == 2'b00; // Only sixteen codes are defined
    cond    = status_flags_in[sel[3:1]] ^ sel[0];
  end

  // Flush field decode
  always_comb
  begin
    fmode    = cpi.ext_word[mbl_pkg::FM_LSB +: 3];
    mask     = cpi.ext_word[mbl_pkg::MASK_LSB +: 4];
    fsrc     = cpi.ext_word[4:0];
    all_q    = fmode == mbl_pkg::FM_ALL;
    addr_q   = fmode[2:1] == mbl_pkg::FM_EA[2:1];
    shared_q = fmode[0];
    fc_ok    = 1'b1;
    fc_val   = 4'h0;
    // Code registers only hold three bits
    if (fsrc[4])
      fc_val = fsrc[3:0];
    else if (fsrc[3])
      fc_val = cpi.dreg_low;
    else if (fsrc == mbl_pkg::FCS_SRC)
      fc_val = {1'b0, cpi.src_code};
    else if (fsrc == mbl_pkg::FCS_DST)
      fc_val = {1'b0, cpi.dst_code};
    else
      fc_ok = 1'b0;
    // Control alterable modes only
    case (cpi.op_word[5:3])
      mbl_pkg::EA_IND, mbl_pkg::EA_DISP, mbl_pkg::EA_IDX: ea_ok = 1'b1;
      mbl_pkg::EA_ABS: ea_ok = (cpi.op_word[2:0] == mbl_pkg::EA_ABSW)
                               || (cpi.op_word[2:0] == mbl_pkg::EA_ABSL);
      default: ea_ok = 1'b0;
    endcase
  end

  // Malformed words fall back to the illegal directive
  always_comb
  begin
    if (is_br)
      illegal = !sel_ok;
    else if (is_loop)
      illegal = !sel_ok || (cpi.ext_word[15:6] != 10'h000);
    else if (is_fl)
      illegal = !(all_q || fmode[2]) || cpi.ext_word[9]
                || (!all_q && !fc_ok) || (addr_q && !ea_ok);
    else
      illegal = 1'b1;
  end

  assign take     = (state_r == mbl_pkg::DS_IDLE) && cpi.req;
  assign flush_go = take && is_fl && !illegal && cpi.supervisor;
  assign ea_tag   = cpi.ea_addr[mbl_pkg::TAG_LSB +: mbl_pkg::TAG_W];

  // Per-entry storage and match
  for (genvar i = 0; i < mbl_pkg::CACHE_N; i++)
  begin : g_ent
    logic                      v_r;
    logic                      shared_r;
    logic [3:0]                fc_r;
    logic [mbl_pkg::TAG_W-1:0] tag_r;
    logic                      hit;

    assign hit = all_q
                 || (((fc_r & mask) == (fc_val & mask))
                     && (shared_q || !shared_r)
                     && (!addr_q || (tag_r == ea_tag)));

    // A load in the flush cycle wins: the new entry is kept
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        v_r   <= 1'b0;
        shared_r <= 1'b0;
        fc_r  <= 4'h0;
        tag_r <= '0;
      end
      else if (load_in && (load_idx_in == 3'(i)))
      begin
        v_r   <= 1'b1;
        shared_r <= load_shared_in;
        fc_r  <= load_fc_in;
        tag_r <= load_tag_in;
      end
      else if (flush_go && hit)
        v_r <= 1'b0;
    end

    assign entry_valid_out[i] = v_r;
  end

  // Handshake; directives land on the same edge as the invalidation
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r           <= mbl_pkg::DS_IDLE;
      cpi.ack           <= 1'b0;
      cpi.dir_trap      <= 1'b0;
      cpi.dir_illegal   <= 1'b0;
      cpi.dir_cond      <= 1'b0;
      cpi.dir_long      <= 1'b0;
      cpi.dir_branch    <= 1'b0;
      cpi.dir_decrement <= 1'b0;
    end
    else
    begin
      case (state_r)
        mbl_pkg::DS_IDLE:
          if (cpi.req)
          begin
            cpi.ack           <= 1'b1;
            // Malformed words report illegal, never a trap
            cpi.dir_illegal   <= illegal;
            cpi.dir_trap      <= !illegal && !cpi.supervisor;
            cpi.dir_cond      <= cond;
            cpi.dir_long      <= is_br && cpi.op_word[mbl_pkg::BR_SIZE_BIT];
            cpi.dir_branch    <= is_br && !illegal && cpi.supervisor && cond;
            cpi.dir_decrement <= is_loop && !illegal && cpi.supervisor && !cond;
            state_r           <= mbl_pkg::DS_ACK;
          end
        mbl_pkg::DS_ACK:
          if (!cpi.req)
          begin
            cpi.ack <= 1'b0;
            state_r <= mbl_pkg::DS_IDLE;
          end
        default:
        begin
          cpi.ack <= 1'b0;
          state_r <= mbl_pkg::DS_IDLE;
        end
      endcase
    end
  end
endmodule : mbl_dev
`default_nettype wire

// *** include/mbl_pkg.sv ***
`default_nettype none
package mbl_pkg;
  // Command word prefixes
  localparam logic [8:0]  OP_BR_PFX    = 9'h1E1;  // Word [15:7]
  localparam logic [12:0] OP_LOOP_PFX  = 13'h1E09; // Word [15:3]
  localparam logic [9:0]  OP_FLUSH_PFX = 10'h3C0; // Word [15:6]
  localparam logic [2:0]  EXT_FLUSH    = 3'h1;    // Ext [15:13]
  // Field positions
  localparam int BR_SIZE_BIT = 6;
  localparam int FM_LSB      = 10;
  localparam int MASK_LSB    = 5;
  // Flush modes
  localparam logic [2:0] FM_ALL = 3'h1;
  localparam logic [2:0] FM_FC  = 3'h4;
  localparam logic [2:0] FM_EA  = 3'h6;
  // Function code sources
  localparam logic [4:0] FCS_SRC = 5'h00;
  localparam logic [4:0] FCS_DST = 5'h01;
  // Address modes
  localparam logic [2:0] EA_IND  = 3'h2;
  localparam logic [2:0] EA_DISP = 3'h5;
  localparam logic [2:0] EA_IDX  = 3'h6;
  localparam logic [2:0] EA_ABS  = 3'h7;
  localparam logic [2:0] EA_ABSW = 3'h0;
  localparam logic [2:0] EA_ABSL = 3'h1;
  // Translation cache shape
  localparam int CACHE_N = 8;
  localparam int TAG_LSB = 12;
  localparam int TAG_W   = 20;
  // Host register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_INSN   = 8'h04;
  localparam logic [7:0] A_EA     = 8'h08;
  localparam logic [7:0] A_PC     = 8'h0C;
  localparam logic [7:0] A_DISP   = 8'h10;
  localparam logic [7:0] A_FCREG  = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_TARGET = 8'h1C;
  localparam logic [7:0] A_DREG   = 8'h20;
  localparam logic [31:0] REG_RST = 32'h00000000;
  // Controller states
  typedef enum logic [1:0] {DS_IDLE = 2'b01, DS_ACK = 2'b10} mbl_dev_state_type;
  typedef enum logic [2:0] {HS_IDLE = 3'b001, HS_REQ = 3'b010, HS_REL = 3'b100}
    mbl_host_state_type;
endpackage : mbl_pkg
`default_nettype wire

// *** include/mbl_cpi_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface mbl_cpi_if;
  logic        req;
  logic        supervisor;
  logic [15:0] op_word;
  logic [15:0] ext_word;
  logic [31:0] ea_addr;
  logic [3:0]  dreg_low;
  logic [2:0]  src_code;
  logic [2:0]  dst_code;
  logic        ack;
  logic        dir_trap;
  logic        dir_illegal;
  logic        dir_cond;
  logic        dir_long;
  logic        dir_branch;
  logic        dir_decrement;
  // Coprocessor end
  modport dev (input req, supervisor, op_word, ext_word, ea_addr, dreg_low, src_code, dst_code,
               output ack, dir_trap, dir_illegal, dir_cond, dir_long, dir_branch,
               dir_decrement);
  // Main processor end
  modport host (output req, supervisor, op_word, ext_word, ea_addr, dreg_low, src_code, dst_code,
                input ack, dir_trap, dir_illegal, dir_cond, dir_long, dir_branch,
                dir_decrement);
endinterface : mbl_cpi_if
`default_nettype wire

// *** rtl/mbl_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module mbl_host (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Coprocessor link
  mbl_cpi_if.host          cpi
);
  mbl_pkg::mbl_host_state_type state_r;
  logic [31:0] insn_r;
  logic [31:0] pc_r;
  logic [31:0] disp_r;
  logic [31:0] target_r;
  logic [31:0] d_r [8];
  logic [5:0]  stat_r;
  logic        wr_pend_r;
  logic [7:0]  a_r;
  logic        go;
  logic [15:0] cnt_lo;
  logic [31:0] ret_pc;
  logic [31:0] rd_mux;

  assign go     = wr_pend_r && (a_r == mbl_pkg::A_CTRL) && hwdata_in[0];
  assign cnt_lo = d_r[insn_r[18:16]][15:0];
  assign ret_pc = pc_r + 32'h00000002;

  // Read data mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (haddr_in[7:5] == mbl_pkg::A_DREG[7:5])
      rd_mux = d_r[haddr_in[4:2]];
    else
      case (haddr_in[7:0])
        mbl_pkg::A_CTRL:   rd_mux = {30'h00000000, cpi.supervisor, 1'b0};
        mbl_pkg::A_INSN:   rd_mux = insn_r;
        mbl_pkg::A_EA:     rd_mux = cpi.ea_addr;
        mbl_pkg::A_PC:     rd_mux = pc_r;
        mbl_pkg::A_DISP:   rd_mux = disp_r;
        mbl_pkg::A_FCREG:  rd_mux = {25'h0000000, cpi.dst_code, 1'b0, cpi.src_code};
        mbl_pkg::A_STATUS: rd_mux = {26'h0000000, stat_r};
        mbl_pkg::A_TARGET: rd_mux = target_r;
        default:           rd_mux = 32'h00000000;
      endcase
  end

  // Bus address phase; zero wait states, always OKAY
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_pend_r     <= 1'b0;
      a_r           <= 8'h00;
      hrdata_out    <= mbl_pkg::REG_RST;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
    else if (hready_in)
    begin
      wr_pend_r <= hsel_in && htrans_in[1] && hwrite_in;
      a_r       <= haddr_in[7:0];
      if (hsel_in && htrans_in[1] && !hwrite_in)
        hrdata_out <= rd_mux;
    end
  end

  // Setup registers; ignored while a command is in flight
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cpi.supervisor <= 1'b0;
      insn_r         <= mbl_pkg::REG_RST;
      cpi.ea_addr    <= mbl_pkg::REG_RST;
      pc_r           <= mbl_pkg::REG_RST;
      disp_r         <= mbl_pkg::REG_RST;
      cpi.src_code   <= 3'h0;
      cpi.dst_code   <= 3'h0;
    end
    else if (wr_pend_r && (state_r == mbl_pkg::HS_IDLE))
      case (a_r)
        mbl_pkg::A_CTRL:  cpi.supervisor <= hwdata_in[1];
        mbl_pkg::A_INSN:  insn_r <= hwdata_in;
        mbl_pkg::A_EA:    cpi.ea_addr <= hwdata_in;
        mbl_pkg::A_PC:    pc_r <= hwdata_in;
        mbl_pkg::A_DISP:  disp_r <= hwdata_in;
        mbl_pkg::A_FCREG:
        begin
          cpi.src_code <= hwdata_in[2:0];
          cpi.dst_code <= hwdata_in[6:4];
        end
        default: ;
      endcase
  end

  // Command issue, data registers and completion
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r      <= mbl_pkg::HS_IDLE;
      cpi.req      <= 1'b0;
      cpi.op_word  <= 16'h0000;
      cpi.ext_word <= 16'h0000;
      cpi.dreg_low <= 4'h0;
      stat_r       <= 6'h00;
      target_r     <= mbl_pkg::REG_RST;
      for (int k = 0; k < 8; k++)
        d_r[k] <= mbl_pkg::REG_RST;
    end
    else
    begin
      if (wr_pend_r && (a_r[7:5] == mbl_pkg::A_DREG[7:5]) && (state_r == mbl_pkg::HS_IDLE))
        d_r[a_r[4:2]] <= hwdata_in;
      case (state_r)
        mbl_pkg::HS_IDLE:
          if (go)
          begin
            cpi.req      <= 1'b1;
            cpi.op_word  <= insn_r[31:16];
            cpi.ext_word <= insn_r[15:0];
            cpi.dreg_low <= d_r[insn_r[2:0]][3:0];
            stat_r       <= 6'h01;
            state_r      <= mbl_pkg::HS_REQ;
          end
        mbl_pkg::HS_REQ:
          if (cpi.ack)
          begin
            cpi.req   <= 1'b0;
            stat_r[2] <= cpi.dir_trap;
            stat_r[3] <= cpi.dir_illegal;
            if (cpi.dir_decrement)
            begin
              d_r[insn_r[18:16]][15:0] <= cnt_lo - 16'h0001;
              stat_r[5] <= 1'b1;
              stat_r[4] <= cnt_lo == 16'h0000;
              target_r  <= ret_pc + {{16{disp_r[15]}}, disp_r[15:0]};
            end
            else if (cpi.dir_branch)
            begin
              stat_r[4] <= 1'b1;
              target_r  <= cpi.dir_long ? ret_pc + disp_r
                           : ret_pc + {{16{disp_r[15]}}, disp_r[15:0]};
            end
            state_r <= mbl_pkg::HS_REL;
          end
        mbl_pkg::HS_REL:
          if (!cpi.ack)
          begin
            stat_r[1:0] <= 2'b10;
            state_r     <= mbl_pkg::HS_IDLE;
          end
        default:
        begin
          cpi.req <= 1'b0;
          state_r <= mbl_pkg::HS_IDLE;
        end
      endcase
    end
  end
endmodule : mbl_host
`default_nettype wire

// *** test/mbl_cpi_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module mbl_cpi_assertions (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  // Link signals
  input wire logic        req,
  input wire logic        supervisor,
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic        ack,
  input wire logic        dir_trap,
  input wire logic        dir_illegal,
  input wire logic        dir_cond,
  input wire logic        dir_long,
  input wire logic        dir_branch,
  input wire logic        dir_decrement
);
  logic br;
  logic lp;
  logic fl;
  logic ok;
  // Command family; words stand while req is high
  assign br = op_word[15:7] == mbl_pkg::OP_BR_PFX;
  assign lp = op_word[15:3] == mbl_pkg::OP_LOOP_PFX;
  assign fl = op_word[15:6] == mbl_pkg::OP_FLUSH_PFX;
  assign ok = !dir_illegal && !dir_trap;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  // Four-phase steps
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_release;
    ack && !req;
  endsequence
  a_take_acks: assert property (s_take |=> ack)
    else $error("ack missing after request");
  a_ack_holds: assert property (ack && req |=> ack && $stable({dir_cond, dir_branch}))
    else $error("answer changed early");
  a_ack_release: assert property (s_release |-> ##[1:2] !ack)
    else $error("ack stuck after release");
  a_priv_trap: assert property ($rose(ack) |-> dir_trap == (!supervisor && !dir_illegal))
    else $error("privilege check wrong");
  a_size_long: assert property ($rose(ack) && br && ok |-> dir_long == op_word[6])
    else $error("size directive wrong");
  a_sel_range: assert property ($rose(ack) && (br && op_word[5:4] != 2'h0 ||
    lp && ext_word[5:4] != 2'h0) |-> dir_illegal) else $error("selector range");
  a_loop_true: assert property ($rose(ack) && lp && dir_cond |-> !dir_decrement
    && !dir_branch) else $error("loop acted on true");
  a_loop_false: assert property ($rose(ack) && lp && ok && !dir_cond |-> dir_decrement)
    else $error("loop missed decrement");
  a_loop_ext: assert property ($rose(ack) && lp && ext_word[15:6] != 10'h0 |-> dir_illegal)
    else $error("loop ext not refused");
  a_mode_bad: assert property ($rose(ack) && fl && ext_word[12:10] inside {3'h0, 3'h2,
    3'h3} |-> dir_illegal) else $error("flush mode not refused");
  a_ea_bad: assert property ($rose(ack) && fl && ext_word[12:11] == 2'h3 &&
    op_word[5:3] inside {3'h0, 3'h1, 3'h3, 3'h4} |-> dir_illegal) else $error("ea mode");
endmodule : mbl_cpi_assertions
`default_nettype wire

// *** test/mmu_branch_loop_flush_decode_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module mmu_branch_loop_flush_decode_tb_top;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [2:0]  hsize      = 3'h2;
  logic [31:0] hwdata     = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [7:0]  flags      = 8'h00;
  logic        load       = 1'b0;
  logic [2:0]  load_idx   = 3'h0;
  logic [3:0]  load_fc    = 4'h0;
  logic        load_shared = 1'b0;
  logic [19:0] load_tag   = 20'h0;
  logic [7:0]  valid;
  logic [31:0] dm [8];
  logic [3:0]  mfc [8];
  logic [19:0] mtag [8];
  logic [7:0]  msg;
  logic [7:0]  mval       = 8'h00;
  int          fails      = 0;
  int          comparisons = 0;
  int          seed       = 22;
  int          cycles     = 0;
  mbl_cpi_if cpi ();
  mbl_dev i_mbl_dev (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cpi(cpi),
    .status_flags_in(flags), .load_in(load), .load_idx_in(load_idx), .load_fc_in(load_fc),
    .load_shared_in(load_shared), .load_tag_in(load_tag), .entry_valid_out(valid));
  mbl_host i_mbl_host (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .cpi(cpi));
  mbl_cpi_assertions i_mbl_cpi_assertions (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .req(cpi.req), .supervisor(cpi.supervisor), .op_word(cpi.op_word), .ext_word(cpi.ext_word),
    .ack(cpi.ack), .dir_trap(cpi.dir_trap), .dir_illegal(cpi.dir_illegal),
    .dir_cond(cpi.dir_cond), .dir_long(cpi.dir_long), .dir_branch(cpi.dir_branch),
    .dir_decrement(cpi.dir_decrement));
  // Clock, 50 ns period
  always #25 clk_sys_in = ~clk_sys_in;
  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic chk_cache(input logic [7:0] e);
    comparisons++;
    if (valid !== e)
    begin
      fails++;
      $display("BAD entry_valid expected %h seen %h", e, valid);
    end
  endtask : chk_cache
  // One single-word transfer; read data taken at the data phase's last edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  // Cache entry load; half of the tags follow the flush address
  task automatic load_entry(input int i, input logic [19:0] tag);
    @(posedge clk_sys_in);
    load <= 1'b1;
    load_idx <= i[2:0];
    load_fc <= 4'($random(seed));
    load_shared <= 1'($random(seed));
    load_tag <= i[0] ? tag : 20'($random(seed));
    @(posedge clk_sys_in);
    load <= 1'b0;
    mfc[i] = load_fc;
    msg[i] = load_shared;
    mtag[i] = load_tag;
    mval[i] = 1'b1;
  endtask : load_entry
  // Issue one command through the host and compare every result with the model
  task automatic run(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] ea,
                     input logic [31:0] disp, input logic sup);
    logic [31:0] r, pc, fcr;
    logic [3:0]  fcv, mk;
    logic [5:0]  sel;
    logic [2:0]  fm, em;
    logic        br, lp, fl, cv, ill, trp, tk, dec, eaok, hit;
    int          n;
    pc = $random(seed);
    fcr = $random(seed) & 32'h77;
    flags <= 8'($random(seed));
    bus(1'b1, mbl_pkg::A_INSN, {op, ext}, r);
    bus(1'b1, mbl_pkg::A_EA, ea, r);
    bus(1'b1, mbl_pkg::A_PC, pc, r);
    bus(1'b1, mbl_pkg::A_DISP, disp, r);
    bus(1'b1, mbl_pkg::A_FCREG, fcr, r);
    bus(1'b1, mbl_pkg::A_CTRL, {30'h0, sup, 1'b1}, r);
    n = 0;
    do begin bus(1'b0, mbl_pkg::A_STATUS, 32'h0, r); n++; end while (r[0] !== 1'b1 && n < 3);
    do begin bus(1'b0, mbl_pkg::A_STATUS, 32'h0, r); n++; end while (r[0] !== 1'b0 && n < 30);
    br = op[15:7] == mbl_pkg::OP_BR_PFX;
    lp = op[15:3] == mbl_pkg::OP_LOOP_PFX;
    fl = op[15:6] == mbl_pkg::OP_FLUSH_PFX && ext[15:13] == mbl_pkg::EXT_FLUSH;
    sel = br ? op[5:0] : ext[5:0];
    fm = ext[12:10];
    em = op[5:3];
    cv = flags[sel[3:1]] ^ sel[0];
    eaok = em inside {3'h2, 3'h5, 3'h6} || (em == 3'h7 && op[2:1] == 2'h0);
    ill = !(br || lp || fl) || ((br || lp) && sel > 6'h0F) || (lp && ext[15:6] != 10'h0);
    ill = ill || (fl && (ext[9] || fm inside {3'h0, 3'h2, 3'h3} || (fm[2:1] == 2'h3 && !eaok)));
    trp = !ill && !sup;
    tk = br && !ill && !trp && cv;
    dec = lp && !ill && !trp && !cv;
    if (dec)
    begin
      dm[op[2:0]][15:0] = dm[op[2:0]][15:0] - 16'h1;
      tk = dm[op[2:0]][15:0] == 16'hFFFF;
    end
    fcv = ext[4] ? ext[3:0] : ext[3] ? dm[ext[2:0]][3:0] : {1'b0, ext[0] ? fcr[6:4] : fcr[2:0]};
    mk = ext[8:5];
    for (int i = 0; i < 8; i++)
    begin
      hit = ((mfc[i] & mk) == (fcv & mk)) && (fm[0] || !msg[i]) && (!fm[1] || mtag[i] == ea[31:12]);
      if (fl && !ill && !trp && (fm == mbl_pkg::FM_ALL || hit))
        mval[i] = 1'b0;
    end
    chk("status", {26'h0, dec, tk, ill, trp, 2'h2}, r);
    if (tk)
    begin
      bus(1'b0, mbl_pkg::A_TARGET, 32'h0, r);
      chk("target", pc + 32'h2 + disp, r);
    end
    if (lp)
    begin
      bus(1'b0, mbl_pkg::A_DREG + {3'h0, op[2:0], 2'h0}, 32'h0, r);
      chk("counter", dm[op[2:0]], r);
    end
    chk_cache(mval);
  endtask : run
  // Main sequence
  initial
  begin
    logic [31:0] r, d, ea;
    logic [2:0]  fm, em, er;
    logic [4:0]  fs;
    logic [3:0]  mk;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    bus(1'b0, mbl_pkg::A_STATUS, 32'h0, r);
    chk("status_reset", mbl_pkg::REG_RST, r);
    chk_cache(8'h00);
    for (int i = 0; i < 8; i++)
    begin
      dm[i] = $random(seed);
      bus(1'b1, mbl_pkg::A_DREG + 8'(4 * i), dm[i], r);
    end
    // Every selector at both sizes, three out of range, one user-state try
    for (int s = 0; s < 35; s++)
    begin
      d = $random(seed);
      if (!s[4] || s > 31)
        d = {{16{d[15]}}, d[15:0]};
      run({mbl_pkg::OP_BR_PFX, s[4], s > 31 ? 6'h10 + 6'(s) : {2'h0, 4'(s)}}, 16'h0, 32'h0, d,
          s != 15);
    end
    // Loop: counter low half at 0, 1 or random; illegal ext and user state
    for (int k = 0; k < 14; k++)
    begin
      er = 3'($random(seed));
      dm[er][15:0] = k % 3 == 0 ? 16'h0 : k % 3 == 1 ? 16'h1 : 16'($random(seed));
      bus(1'b1, mbl_pkg::A_DREG + {3'h0, er, 2'h0}, dm[er], r);
      d = $random(seed);
      run({mbl_pkg::OP_LOOP_PFX, er}, {k == 13 ? 10'h200 : 10'h0, 2'h0, 4'($random(seed))},
          32'h0, {{16{d[15]}}, d[15:0]}, k != 12);
    end
    // Flush: every mode and source, bad modes, bad address modes, user state
    for (int k = 0; k < 32; k++)
    begin
      ea = $random(seed);
      for (int i = 0; i < 8; i++)
        load_entry(i, ea[31:12]);
      fm = 3'(k % 8 < 5 ? 32'h76541 >> (4 * (k % 8)) : 32'h320 >> (4 * (k % 8 - 5)));
      em = k == 11 ? 3'h3 : k == 19 ? 3'h7 : k == 27 ? 3'h0 : 3'(32'h70652 >> (4 * (k % 5)));
      er = k == 19 ? 3'h2 : 3'(k % 2);
      fs = k % 4 == 0 ? {1'b1, 4'($random(seed))} : k % 4 == 1 ? {2'h1, 3'($random(seed))} :
           {4'h0, 1'(k % 4 == 3)};
      // Flush-all is issued with mask and source cleared
      mk = fm == mbl_pkg::FM_ALL ? 4'h0 : 4'($random(seed));
      if (fm == mbl_pkg::FM_ALL)
        fs = 5'h00;
      run({mbl_pkg::OP_FLUSH_PFX, em, er}, {mbl_pkg::EXT_FLUSH, fm, 1'b0, mk, fs},
          ea, 32'h0, k != 16);
    end
    end_sim();
  end
endmodule : mmu_branch_loop_flush_decode_tb_top
`default_nettype wire
